//--- spb_regs.svh
// constants for the sector protection block: offsets, fields, reset values, timing
`ifndef SPB_REGS_SVH
`define SPB_REGS_SVH
// ************************************************************
// apb register offsets (byte addresses)
// ************************************************************
`define SPB_OFF_CTRL      12'h000
`define SPB_OFF_ADDR      12'h004
`define SPB_OFF_CMD       12'h008
`define SPB_OFF_STATUS    12'h00c
`define SPB_OFF_QUERY     12'h010
`define SPB_OFF_PWD_LO    12'h014
`define SPB_OFF_PWD_HI    12'h018
// ************************************************************
// field positions
// ************************************************************
`define SPB_CTRL_TOPSEL   0
`define SPB_CTRL_PWDMODE  1
`define SPB_ST_BUSY       0
`define SPB_ST_LOCK       1
`define SPB_ST_PERR       2
`define SPB_ST_PROTE      3
`define SPB_ST_ARRBLOCK   4
// ************************************************************
// command codes written to the command register
// ************************************************************
`define SPB_CMD_PPB_PROG  4'h1
`define SPB_CMD_PPB_ERASE 4'h2
`define SPB_CMD_DYB_WRITE 4'h3
`define SPB_CMD_LOCK_CLR  4'h4
`define SPB_CMD_UNLOCK    4'h5
`define SPB_CMD_SW_RESET  4'h6
`define SPB_CMD_CLR_ERR   4'h7
// ************************************************************
// address map and reset values
// ************************************************************
`define SPB_TOP_BASE      25'h1fe0000
`define SPB_LOCK_PERSIST  1'h1
`define SPB_LOCK_PASSWORD 1'h0
`define SPB_PPB_ERASED    1'h1
// ************************************************************
// timing: microseconds and the 40 MHz cycle counts
// ************************************************************
`define SPB_CLK_MHZ       40
`define SPB_PROG_US       200
`define SPB_ERASE_US      45000
`define SPB_PROG_CYC      (`SPB_PROG_US * `SPB_CLK_MHZ)
`define SPB_ERASE_CYC     (`SPB_ERASE_US * `SPB_CLK_MHZ)
`endif

//--- spb_pkg.sv
// types shared by the sector protection block
package spb_pkg;
    // sequencer states
    typedef enum logic [1:0] {
        SpbIdle,
        SpbProg,
        SpbErase
    } spb_state_type;
endpackage

//--- spb_bit_mem.sv
// bit array with per-bit write, global fill and registered read
module spb_bit_mem #(
    parameter int DEPTH   = 542,
    parameter int AW      = 10,
    parameter bit INITVAL = 1'b1
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          wrEn,
    input  wire logic [AW-1:0] wrIdx,
    input  wire logic          wrVal,
    input  wire logic          fillEn,
    input  wire logic          fillVal,
    input  wire logic [AW-1:0] rdIdx,
    output logic               rdBit
);
    // storage, one flag per protection unit; power-up image is INITVAL
    logic [DEPTH-1:0] bits_q = {DEPTH{INITVAL}};

    // per-bit write or whole-array fill; fill wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bits_q <= {DEPTH{INITVAL}};
        end else if (fillEn) begin
            bits_q <= {DEPTH{fillVal}};
        end else if (wrEn && (int'(wrIdx) < DEPTH)) begin
            bits_q[wrIdx] <= wrVal;
        end
    end

    // registered read, out-of-range reads as protected
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdBit <= INITVAL;
        end else if (int'(rdIdx) < DEPTH) begin
            rdBit <= bits_q[rdIdx];
        end else begin
            rdBit <= 1'b0;
        end
    end
endmodule

//--- spb_op_timer.sv
// busy timer for persistent bit program and erase
module spb_op_timer #(
    parameter int CW = 21
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          start,
    input  wire logic [CW-1:0] cycles,
    output logic               busy,
    output logic               done
);
    // remaining cycles
    logic [CW-1:0] cnt_q;

    // load on start, count down to zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (start) begin
            cnt_q <= cycles;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign busy = (cnt_q != '0);
    assign done = (cnt_q == CW'(1));
endmodule

//--- spb_sector_protect.sv
// sector protection block: persistent and dynamic bits, lock bit, apb slave
// What this block does
// - top region gets per-4K-sector bit pairs
// - persistent bits nonvolatile, program single, erase all
// - program writes 0, erase sets all 1
// - busy reported during program and erase
// - array reads blocked while programming persistent bit
// - group erase only, no address needed
// - persistent bits start erased to 1
// - dynamic write stores 0 protect, 1 open
// - unprotected only when both bits 1
// - dynamic writes allowed regardless of lock
// - dynamic bits open after any reset
// - lock bit 0 freezes, 1 permits persistent
// - locked program or erase aborts unchanged
// - persistent mode: lock 1 at reset, cleared by command, never set again
// - password mode: lock 0, set by unlock
// - software reset leaves lock bit alone
// - failed unlock sets both error flags
// - mode chosen by one-time configuration bit (here writable once after each reset, which clears it to persistent)
//
// The APB register port and the placing of the registers were decided locally.
`include "spb_regs.svh"
module spb_sector_protect #(
    parameter int   NBLK       = 512,
    parameter int   NTOP       = 32,
    parameter int   UNITS      = 542,
    parameter int   IW         = 10,
    parameter int   CW         = 21,
    parameter int   PROG_CYC   = `SPB_PROG_CYC,
    parameter int   ERASE_CYC  = `SPB_ERASE_CYC,
    parameter logic [63:0] PASSWORD = 64'h0123456789abcdef // arbitrary default
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic [24:0] checkAddr,
    output logic             checkAllowed,
    output logic             arrayReadBlocked,
    output logic             busy
);
    // ************************************************************
    // declarations
    // ************************************************************
    logic            topSel_q;      // top parameter selection
    logic            pwdMode_q;     // one-time mode bit
    logic            modeFixed_q;   // mode bit already programmed
    logic [24:0]     addr_q;        // target address register
    logic [63:0]     pwd_q;         // password candidate
    logic            lock_q;        // lock over persistent bits
    logic            pErr_q;        // program error flag
    logic            protErr_q;     // protection error flag
    logic            queryPpb_q;    // read back of persistent bit
    logic            queryDyb_q;    // read back of dynamic bit
    logic            modeSet;       // first mode write picks password
    spb_pkg::spb_state_type state_q;
    logic            wrAcc;         // apb write access phase
    logic            rdAcc;         // apb read access phase
    logic [3:0]      cmd;           // command code
    logic [IW-1:0]   cmdIdx;        // unit of addr_q
    logic [IW-1:0]   chkIdx;        // unit of checkAddr
    logic            ppbRd;
    logic            dybRd;
    logic            ppbWr;
    logic            ppbFill;
    logic            dybWr;
    logic            dybFill;
    logic            tmrStart;
    logic [CW-1:0]   tmrCycles;
    logic            tmrBusy;
    logic            tmrDone;
    logic            ppbChk;
    logic            dybChk;

    // ************************************************************
    // address to protection unit decode
    // ************************************************************
    // top region splits into 4K sectors, every other block shares one pair
    // with the top layout off, blocks 510 and 511 keep one pair each
    function automatic logic [IW-1:0] unitOf(input logic [24:0] a, input logic top);
        logic [IW-1:0] u;
        u = IW'(a[24:16]);
        if (top && (a >= `SPB_TOP_BASE)) begin
            u = IW'(NBLK - 2) + IW'(a[16:12]);
        end
        return u;
    endfunction

    assign cmdIdx = unitOf(addr_q, topSel_q);
    assign chkIdx = unitOf(checkAddr, topSel_q);

    // ************************************************************
    // apb slave: zero wait, unmapped reads zero with error
    // ************************************************************
    // no wait states: every register answers in its access cycle
    assign pready = 1'b1;
    assign wrAcc  = psel && penable && pwrite;
    assign rdAcc  = psel && penable && !pwrite;
    assign cmd    = pwdata[3:0];

    // error for unmapped offsets
    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            case (paddr)
                `SPB_OFF_CTRL, `SPB_OFF_ADDR, `SPB_OFF_CMD, `SPB_OFF_STATUS,
                `SPB_OFF_QUERY, `SPB_OFF_PWD_LO, `SPB_OFF_PWD_HI: pslverr = 1'b0;
                default: pslverr = 1'b1;
            endcase
        end
    end

    // read data registered at the edge that ends the setup phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `SPB_OFF_CTRL:   prdata <= {30'h0, pwdMode_q, topSel_q};
                `SPB_OFF_ADDR:   prdata <= {7'h0, addr_q};
                `SPB_OFF_STATUS: prdata <= {27'h0, arrayReadBlocked, protErr_q, pErr_q,
                                            lock_q, busy};
                `SPB_OFF_QUERY:  prdata <= {30'h0, queryDyb_q, queryPpb_q};
                default:         prdata <= 32'h0;
            endcase
        end
    end

    // configuration: mode bit may be programmed once after reset (otp image)
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            topSel_q    <= 1'b0;
            pwdMode_q   <= 1'b0;
            modeFixed_q <= 1'b0;
        end else if (wrAcc && paddr == `SPB_OFF_CTRL) begin
            topSel_q <= pwdata[`SPB_CTRL_TOPSEL];
            if (!modeFixed_q) begin
                pwdMode_q   <= pwdata[`SPB_CTRL_PWDMODE];
                modeFixed_q <= 1'b1;
            end
        end
    end

    // the mode bit is rewritten after each reset, so only the first write counts
    assign modeSet = wrAcc && (paddr == `SPB_OFF_CTRL) && !modeFixed_q &&
                     pwdata[`SPB_CTRL_PWDMODE];

    // target address and password candidate
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_q <= 25'h0;
            pwd_q  <= 64'h0;
        end else if (wrAcc) begin
            if (paddr == `SPB_OFF_ADDR) begin
                addr_q <= pwdata[24:0];
            end
            if (paddr == `SPB_OFF_PWD_LO) begin
                pwd_q[31:0] <= pwdata;
            end
            if (paddr == `SPB_OFF_PWD_HI) begin
                pwd_q[63:32] <= pwdata;
            end
        end
    end

    // ************************************************************
    // command sequencer
    // ************************************************************
    logic cmdWr;
    assign cmdWr = wrAcc && (paddr == `SPB_OFF_CMD);

    // program and erase only start idle and unlocked
    assign tmrStart = cmdWr && (state_q == spb_pkg::SpbIdle) && lock_q &&
                      (cmd == `SPB_CMD_PPB_PROG || cmd == `SPB_CMD_PPB_ERASE);
    assign tmrCycles = (cmd == `SPB_CMD_PPB_ERASE) ? CW'(ERASE_CYC) : CW'(PROG_CYC);

    // state walk
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= spb_pkg::SpbIdle;
        end else begin
            case (state_q)
                spb_pkg::SpbIdle: begin
                    if (tmrStart) begin
                        state_q <= (cmd == `SPB_CMD_PPB_ERASE) ? spb_pkg::SpbErase
                                                                : spb_pkg::SpbProg;
                    end
                end
                spb_pkg::SpbProg, spb_pkg::SpbErase: begin
                    if (tmrDone) begin
                        state_q <= spb_pkg::SpbIdle;
                    end
                end
                default: state_q <= spb_pkg::SpbIdle;
            endcase
        end
    end

    // persistent bit changes commit at the end of the busy time
    assign ppbWr   = tmrDone && (state_q == spb_pkg::SpbProg);
    assign ppbFill = tmrDone && (state_q == spb_pkg::SpbErase);
    // dynamic write any time; software reset reopens all
    assign dybWr   = cmdWr && (cmd == `SPB_CMD_DYB_WRITE);
    assign dybFill = cmdWr && (cmd == `SPB_CMD_SW_RESET);

    // busy and array read gating
    assign busy             = (state_q != spb_pkg::SpbIdle);
    assign arrayReadBlocked = (state_q == spb_pkg::SpbProg);

    // ************************************************************
    // lock bit and error flags
    // ************************************************************
    // lock bit: set by reset, cleared once password mode is picked or by command,
    // set again only by a good unlock in password mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_q <= `SPB_LOCK_PERSIST;
        end else begin
            if (modeSet) begin
                lock_q <= `SPB_LOCK_PASSWORD;
            end else if (cmdWr && cmd == `SPB_CMD_LOCK_CLR) begin
                lock_q <= 1'b0;
            end else if (cmdWr && cmd == `SPB_CMD_UNLOCK && pwdMode_q &&
                         pwd_q == PASSWORD) begin
                lock_q <= 1'b1;
            end
            // software reset has no branch here on purpose
        end
    end

    // error flags: set wins over clear
    // an unlock in persistent mode can never succeed, so it fails like a bad one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pErr_q    <= 1'b0;
            protErr_q <= 1'b0;
        end else begin
            logic failUnlock;
            logic failLocked;
            failUnlock = cmdWr && cmd == `SPB_CMD_UNLOCK && (!pwdMode_q || pwd_q != PASSWORD);
            failLocked = cmdWr && !lock_q &&
                         (cmd == `SPB_CMD_PPB_PROG || cmd == `SPB_CMD_PPB_ERASE);
            if (failUnlock || failLocked) begin
                pErr_q    <= 1'b1;
                protErr_q <= 1'b1;
            end else if (cmdWr && cmd == `SPB_CMD_CLR_ERR) begin
                pErr_q    <= 1'b0;
                protErr_q <= 1'b0;
            end
        end
    end

    // ************************************************************
    // bit arrays and the protection decision
    // ************************************************************
    // persistent copy has no reset: it keeps its state across a hardware reset
    spb_bit_mem #(.DEPTH(UNITS), .AW(IW), .INITVAL(`SPB_PPB_ERASED)) uPpb (
        .clk    (clk),
        .rst    (1'b0),
        .wrEn   (ppbWr),
        .wrIdx  (cmdIdx),
        .wrVal  (1'b0),
        .fillEn (ppbFill),
        .fillVal(1'b1),
        .rdIdx  (chkIdx),
        .rdBit  (ppbChk)
    );

    spb_bit_mem #(.DEPTH(UNITS), .AW(IW), .INITVAL(1'b1)) uDyb (
        .clk    (clk),
        .rst    (rst),
        .wrEn   (dybWr),
        .wrIdx  (cmdIdx),
        .wrVal  (pwdata[4]),
        .fillEn (dybFill),
        .fillVal(1'b1),
        .rdIdx  (chkIdx),
        .rdBit  (dybChk)
    );

    // query latches the addressed pair from the check path
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            queryPpb_q <= 1'b1;
            queryDyb_q <= 1'b1;
        end else begin
            // software must set checkAddr a few cycles before reading the query
            queryPpb_q <= ppbRd;
            queryDyb_q <= dybRd;
        end
    end

    // allowed only with both bits 1 and nothing running
    // busy gates it too: a running job owns the array until it ends
    assign checkAllowed = ppbChk && dybChk && !busy;

    assign ppbRd = ppbChk;
    assign dybRd = dybChk;

    // one timer serves program and erase; only one job runs at a time
    spb_op_timer #(.CW(CW)) uTmr (
        .clk   (clk),
        .rst   (rst),
        .start (tmrStart),
        .cycles(tmrCycles),
        .busy  (tmrBusy),
        .done  (tmrDone)
    );

    // ************************************************************
    // assertions
    // ************************************************************
    a_lock_stays_clear: assert property (@(posedge clk) disable iff (rst)
        (!lock_q && !pwdMode_q) |=> !lock_q) else $error("lock set again");
    a_locked_no_start: assert property (@(posedge clk) disable iff (rst)
        (cmdWr && !lock_q && state_q == spb_pkg::SpbIdle) |=> state_q == spb_pkg::SpbIdle)
        else $error("locked command started");
    a_busy_in_op: assert property (@(posedge clk) disable iff (rst)
        tmrStart |=> busy [*2]) else $error("busy not shown");
    a_block_on_prog: assert property (@(posedge clk) disable iff (rst)
        (state_q == spb_pkg::SpbProg) |-> (arrayReadBlocked && tmrBusy))
        else $error("array not blocked");
    a_busy_timer: assert property (@(posedge clk) disable iff (rst)
        tmrBusy |-> busy) else $error("timer runs while idle");
    a_pwd_lock_clear: assert property (@(posedge clk) disable iff (rst)
        modeSet |=> !lock_q) else $error("lock open in password mode");
    a_protect_gate: assert property (@(posedge clk) disable iff (rst)
        (!ppbChk || !dybChk) |-> !checkAllowed) else $error("protected allowed");
    a_unlock_fail: assert property (@(posedge clk) disable iff (rst)
        (cmdWr && cmd == `SPB_CMD_UNLOCK && pwd_q != PASSWORD) |=> (pErr_q && protErr_q))
        else $error("fail flags missing");
    a_swreset_lock: assert property (@(posedge clk) disable iff (rst)
        (cmdWr && cmd == `SPB_CMD_SW_RESET) |=> lock_q == $past(lock_q))
        else $error("lock changed by sw reset");
    a_prog_time: assert property (@(posedge clk) disable iff (rst)
        (tmrStart && cmd == `SPB_CMD_PPB_PROG) |=> !ppbWr [*8]) else $error("early commit");
endmodule

//--- spb_host_model.sv
// host side model: apb master that issues the protection commands
module spb_host_model (
    input  wire logic        clk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // idle bus
    // ************************************************************
    // idle values differ from any real request
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'hfff;
        pwdata = 32'hdead_beef;
    end
    // ************************************************************
    // one transfer: setup, access until pready, then release
    // ************************************************************
    // ok stays low when pready never came within the bound
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err, output logic ok);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge clk);
            n++;
        end
        ok = (pready === 1'b1);
        rdata = prdata;
        err = pslverr;
        // released lines show a changed value, never the stale one
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~addr;
        pwdata <= ~wdata;
    endtask
endmodule

//--- spb_sector_protect_bench.sv
// self-checking bench for the sector protection block
`include "spb_regs.svh"
module spb_sector_protect_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // signals, design and host model
    // ************************************************************
    localparam logic [63:0] PWD = 64'h5a5a0f0f3c3ca5a5; // arbitrary test password
    logic        clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [24:0] checkAddr;
    logic        checkAllowed, arrayReadBlocked, busy;
    int          err_total = 0;
    int          comparisons = 0;
    typedef struct {
        logic [24:0] wrAddr;
        logic [24:0] chkAddr;
        logic        expAllowed;
    } spb_row_type;
    // dynamic bit cleared at wrAddr, protection seen at chkAddr
    spb_row_type rows [8] = '{
        '{25'h0000000, 25'h000f000, 1'b0}, '{25'h0010000, 25'h0020000, 1'b1},
        '{25'h1fe0000, 25'h1fe0000, 1'b0}, '{25'h1fe0000, 25'h1fe1000, 1'b1},
        '{25'h1fd0000, 25'h1fdf000, 1'b0}, '{25'h1fff000, 25'h1fff000, 1'b0},
        '{25'h1fff000, 25'h1ffe000, 1'b1}, '{25'h1fd0000, 25'h1fe0000, 1'b1}};
    spb_sector_protect #(.PROG_CYC(10), .ERASE_CYC(20), .PASSWORD(PWD)) dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .checkAddr(checkAddr), .checkAllowed(checkAllowed),
        .arrayReadBlocked(arrayReadBlocked), .busy(busy));
    spb_host_model host (
        .clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    // ************************************************************
    // clock (reset is driven from the main sequence)
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ************************************************************
    // report and compare tasks
    // ************************************************************
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // a wait that ran out is a mismatch and ends the run
    task automatic timedOut();
        err_total++;
        $display("[ERR] wait bound reached");
        complete_run();
    endtask
    task automatic chkBit(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic chkField(input string name, input logic [4:0] exp, input logic [4:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask
    // ************************************************************
    // bus and command helpers
    // ************************************************************
    task automatic regAcc(input logic wr, input logic [11:0] a, input logic [31:0] d,
                          output logic [31:0] r, output logic e);
        logic ok;
        host.xfer(wr, a, d, r, e, ok);
        if (!ok) begin
            timedOut();
        end
    endtask
    task automatic regWr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        regAcc(1'b1, a, d, r, e);
    endtask
    // busy is polled between edges so that a just-started job is seen
    task automatic waitIdle();
        int n;
        n = 0;
        @(negedge clk);
        while (busy !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) begin
            timedOut();
        end
    endtask
    task automatic cmd(input logic [3:0] code, input logic v, input logic [24:0] a);
        waitIdle();
        regWr(`SPB_OFF_ADDR, {7'h00, a});
        regWr(`SPB_OFF_CMD, {27'h0000000, v, code});
    endtask
    task automatic stat(input logic [4:0] exp);
        logic [31:0] r;
        logic        e;
        waitIdle();
        regAcc(1'b0, `SPB_OFF_STATUS, 32'h00000000, r, e);
        chkField("status", exp, r[4:0]);
    endtask
    // lookup is registered: give it settled cycles before looking
    task automatic look(input logic [24:0] a);
        @(posedge clk);
        checkAddr <= a;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic qry(input logic [24:0] a, input logic [4:0] exp);
        logic [31:0] r;
        logic        e;
        waitIdle();
        look(a);
        regAcc(1'b0, `SPB_OFF_QUERY, 32'h00000000, r, e);
        chkField("query", exp, r[4:0]);
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [31:0] r;
        logic        e;
        rst = 1'b1;
        checkAddr = 25'h0000000;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        stat(5'b00010);
        qry(25'h1fe0000, 5'b00011);
        regAcc(1'b0, 12'h01c, 32'h00000000, r, e);
        chkBit("unmapped", 1'b1, e);
        regWr(`SPB_OFF_CTRL, 32'h00000001);
        // table of dynamic bit mappings in the top parameter layout
        foreach (rows[i]) begin
            cmd(`SPB_CMD_DYB_WRITE, 1'b0, rows[i].wrAddr);
            qry(rows[i].chkAddr, {3'b000, rows[i].expAllowed, 1'b1});
            chkBit("allowed", rows[i].expAllowed, checkAllowed);
            cmd(`SPB_CMD_DYB_WRITE, 1'b1, rows[i].wrAddr);
        end
        // persistent program: busy, array reads held off, decision closed
        look(25'h0000000);
        cmd(`SPB_CMD_PPB_PROG, 1'b0, 25'h1fe1000);
        @(negedge clk);
        chkBit("busy", 1'b1, busy);
        chkBit("readblock", 1'b1, arrayReadBlocked);
        chkBit("allowed", 1'b0, checkAllowed);
        waitIdle();
        qry(25'h1fe1000, 5'b00010);
        chkBit("allowed", 1'b0, checkAllowed);
        qry(25'h1fe2000, 5'b00011);
        // group erase with an unrelated address
        cmd(`SPB_CMD_PPB_ERASE, 1'b0, 25'h0123000);
        @(negedge clk);
        chkBit("busy", 1'b1, busy);
        chkBit("readblock", 1'b0, arrayReadBlocked);
        qry(25'h1fe1000, 5'b00011);
        // configure first, then freeze the persistent bits
        cmd(`SPB_CMD_PPB_PROG, 1'b0, 25'h0000000);
        cmd(`SPB_CMD_LOCK_CLR, 1'b0, 25'h0000000);
        stat(5'b00000);
        cmd(`SPB_CMD_PPB_PROG, 1'b0, 25'h0010000);
        stat(5'b01100);
        qry(25'h0010000, 5'b00011);
        cmd(`SPB_CMD_PPB_ERASE, 1'b0, 25'h0000000);
        qry(25'h0000000, 5'b00010);
        cmd(`SPB_CMD_DYB_WRITE, 1'b0, 25'h0020000);
        qry(25'h0020000, 5'b00001);
        regWr(`SPB_OFF_PWD_LO, PWD[31:0]);
        regWr(`SPB_OFF_PWD_HI, PWD[63:32]);
        cmd(`SPB_CMD_UNLOCK, 1'b0, 25'h0000000);
        stat(5'b01100);
        cmd(`SPB_CMD_CLR_ERR, 1'b0, 25'h0000000);
        cmd(`SPB_CMD_SW_RESET, 1'b0, 25'h0000000);
        stat(5'b00000);
        qry(25'h0020000, 5'b00011);
        // hardware reset reopens the lock, persistent bits survive
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        stat(5'b00010);
        qry(25'h0000000, 5'b00010);
        // password mode: wrong then right password
        regWr(`SPB_OFF_CTRL, 32'h00000002);
        stat(5'b00000);
        cmd(`SPB_CMD_LOCK_CLR, 1'b0, 25'h0000000);
        regWr(`SPB_OFF_PWD_LO, ~PWD[31:0]);
        regWr(`SPB_OFF_PWD_HI, PWD[63:32]);
        cmd(`SPB_CMD_UNLOCK, 1'b0, 25'h0000000);
        stat(5'b01100);
        cmd(`SPB_CMD_CLR_ERR, 1'b0, 25'h0000000);
        regWr(`SPB_OFF_PWD_LO, PWD[31:0]);
        cmd(`SPB_CMD_UNLOCK, 1'b0, 25'h0000000);
        stat(5'b00010);
        cmd(`SPB_CMD_PPB_ERASE, 1'b0, 25'h0000000);
        qry(25'h0000000, 5'b00011);
        complete_run();
    end
endmodule
